// ==== include/bcc_pkg.sv ====
// shared constants, types and helpers for the bus control configuration block
package bcc_pkg;

  localparam int unsigned ADDR_W   = 24;
  localparam int unsigned PADDR_W  = 8;
  localparam int unsigned AREAS    = 8;
  localparam int unsigned AREA_LSB = 21;

  // register byte addresses on the apb bus
  localparam logic [PADDR_W-1:0] OFS_BUS_CTRL_UPPER = 8'h00;
  localparam logic [PADDR_W-1:0] OFS_BUS_CTRL_LOWER = 8'h04;

  localparam logic [7:0] RST_BUS_CTRL_UPPER = 8'hd0;
  localparam logic [7:0] RST_BUS_CTRL_LOWER = 8'h3c;

  // upper register fields
  localparam int unsigned BIT_IDLE_CROSS_AREA_READ = 7;
  localparam int unsigned BIT_IDLE_READ_WRITE      = 6;
  localparam int unsigned BIT_AREA0_BURST_ENABLE   = 5;
  localparam int unsigned BIT_BURST_CYCLE_LEN      = 4;
  localparam int unsigned BIT_BURST_WORD_MAX       = 3;
  // lower register fields
  localparam int unsigned BIT_BUS_RELEASE_ENABLE   = 7;
  localparam int unsigned BIT_REQ_DROP_OUT_ENABLE  = 6;
  localparam int unsigned BIT_EXT_ADDR_WINDOW_EN   = 5;
  localparam int unsigned BIT_WAIT_PIN_ENABLE      = 0;

  // external address window
  localparam logic [ADDR_W-1:0] WIN_LO = 24'h010000;
  localparam logic [ADDR_W-1:0] ROM_HI = 24'h01ffff;
  localparam logic [ADDR_W-1:0] WIN_HI = 24'h03ffff;

  // wait timing in states of pclk, burst limits in words, word size in bytes
  localparam logic [1:0] PROG_WAITS_RST = 2'h3;
  localparam logic [3:0] BURST_WORDS_SHORT = 4'h4;
  localparam logic [3:0] BURST_WORDS_LONG  = 4'h8;
  localparam int unsigned WORD_BYTES = 2;

  typedef struct packed {
    logic idle_cross_area_read;
    logic idle_read_write;
    logic area0_burst_enable;
    logic burst_cycle_len;
    logic burst_word_max;
    logic bus_release_enable;
    logic req_drop_out_enable;
    logic ext_addr_window_enable;
    logic wait_pin_enable;
  } cfg_t;

  typedef enum logic [1:0] {
    SPACE_EXT  = 2'b00,
    SPACE_ROM  = 2'b01,
    SPACE_RSVD = 2'b10
  } space_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
  } ext_req_t;

  typedef struct packed {
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [PADDR_W-1:0] paddr;
    logic [31:0]        pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_GAP      = 3'b001,
    ST_T1       = 3'b010,
    ST_T2       = 3'b011,
    ST_TW       = 3'b100,
    ST_T3       = 3'b101,
    ST_BURST    = 3'b110,
    ST_RELEASED = 3'b111
  } seq_state_t;

  function automatic logic [2:0] area_of(input logic [ADDR_W-1:0] a);
    area_of = a[ADDR_W-1:AREA_LSB];
  endfunction : area_of

endpackage : bcc_pkg

// ==== rtl/bcc_regs.sv ====
// apb slave holding the two bus control registers
`timescale 1ns/1ns
module bcc_regs (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              hw_standby,
  input  wire bcc_pkg::apb_req_t apb_in,
  output bcc_pkg::apb_rsp_t      apb_out,
  output bcc_pkg::cfg_t          cfg
);
  import bcc_pkg::*;

  logic [7:0] upper_ff;
  logic [7:0] lower_ff;
  logic       setup;
  logic       hit_upper;
  logic       hit_lower;
  logic       wr_now;

  assign setup     = apb_in.psel && !apb_in.penable;
  assign hit_upper = apb_in.paddr == OFS_BUS_CTRL_UPPER;
  assign hit_lower = apb_in.paddr == OFS_BUS_CTRL_LOWER;
  // write lands at the edge where pready is sampled high
  assign wr_now    = apb_in.psel && apb_in.penable && apb_out.pready && apb_in.pwrite;

  // software standby is not an input here, so contents simply persist through it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_ff <= RST_BUS_CTRL_UPPER;
      lower_ff <= RST_BUS_CTRL_LOWER;
    end else if (hw_standby) begin
      upper_ff <= RST_BUS_CTRL_UPPER;
      lower_ff <= RST_BUS_CTRL_LOWER;
    end else if (wr_now) begin
      // reserved bits are kept as plain storage
      if (hit_upper) upper_ff <= apb_in.pwdata[7:0];
      if (hit_lower) lower_ff <= apb_in.pwdata[7:0];
    end
  end

  // one wait-free access phase: ready raised for the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_out <= '0;
    end else if (setup) begin
      apb_out.pready  <= 1'b1;
      apb_out.pslverr <= !(hit_upper || hit_lower);
      apb_out.prdata  <= hit_upper ? {24'h000000, upper_ff} :
                         hit_lower ? {24'h000000, lower_ff} : 32'h00000000;
    end else begin
      apb_out <= '0;
    end
  end

  always_comb begin
    cfg.idle_cross_area_read   = upper_ff[BIT_IDLE_CROSS_AREA_READ];
    cfg.idle_read_write        = upper_ff[BIT_IDLE_READ_WRITE];
    cfg.area0_burst_enable     = upper_ff[BIT_AREA0_BURST_ENABLE];
    cfg.burst_cycle_len        = upper_ff[BIT_BURST_CYCLE_LEN];
    cfg.burst_word_max         = upper_ff[BIT_BURST_WORD_MAX];
    cfg.bus_release_enable     = lower_ff[BIT_BUS_RELEASE_ENABLE];
    cfg.req_drop_out_enable    = lower_ff[BIT_REQ_DROP_OUT_ENABLE];
    cfg.ext_addr_window_enable = lower_ff[BIT_EXT_ADDR_WINDOW_EN];
    cfg.wait_pin_enable        = lower_ff[BIT_WAIT_PIN_ENABLE];
  end

endmodule : bcc_regs

// ==== rtl/bcc_space_decode.sv ====
// classifies an address as external, on-chip rom or reserved
`timescale 1ns/1ns
module bcc_space_decode (
  input  wire logic [bcc_pkg::ADDR_W-1:0] addr,
  input  wire logic                       ext_addr_window_enable,
  input  wire logic                       expanded_mode,
  output bcc_pkg::space_t                 space
);
  import bcc_pkg::*;

  logic in_win;
  logic in_rom;

  assign in_win = addr >= WIN_LO && addr <= WIN_HI;
  assign in_rom = addr >= WIN_LO && addr <= ROM_HI;

  always_comb begin
    if (!expanded_mode) begin
      space = in_rom && !ext_addr_window_enable ? SPACE_ROM : SPACE_RSVD;
    end else if (in_win && !ext_addr_window_enable) begin
      space = in_rom ? SPACE_ROM : SPACE_RSVD;
    end else begin
      space = SPACE_EXT;
    end
  end

endmodule : bcc_space_decode

// ==== rtl/bus_control_config_regs.sv ====
// bus control registers and the external cycle sequencer they steer
`timescale 1ns/1ns
module bus_control_config_regs (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       hw_standby,
  input  wire logic                       expanded_mode,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [bcc_pkg::PADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire bcc_pkg::ext_req_t          int_req,
  output logic                            int_ack,
  output logic                            int_fault,
  input  wire logic                       wait_n,
  input  wire logic                       ext_master_request_n,
  output logic                            bus_ack_n,
  output logic                            bus_ack_oe,
  output logic                            request_drop_n,
  output logic                            request_drop_oe,
  output logic      [bcc_pkg::AREAS-1:0]  area_select_n,
  output logic      [bcc_pkg::ADDR_W-1:0] ext_addr,
  output logic                            ext_rd_n,
  output logic                            ext_wr_n,
  output logic                            area0_burst_mode
);
  import bcc_pkg::*;

  apb_req_t   apb_in;
  apb_rsp_t   apb_out;
  cfg_t       cfg;
  cfg_t       cyc_cfg_ff;
  space_t     space;
  seq_state_t state_ff;
  seq_state_t nxt_state;

  logic [ADDR_W-1:0] addr_ff;
  logic              write_ff;
  logic [2:0]        area_ff;
  logic [1:0]        wait_cnt_ff;
  logic              burst_step_ff;
  logic [3:0]        burst_cnt_ff;
  logic              last_read_ff;
  logic [2:0]        last_area_ff;
  logic              last_valid_ff;
  logic              burst_open_ff;
  logic [ADDR_W-1:0] burst_next_ff;
  logic              need_gap;
  logic              can_burst;
  logic              ext_start;
  logic              release_req;
  logic              ack_ff;
  logic              fault_ff;
  logic              bus_ack_n_ff;
  logic              drop_n_ff;
  logic              drop_oe_ff;
  logic              ack_oe_ff;
  logic [AREAS-1:0]  sel_n_ff;
  logic              rd_n_ff;
  logic              wr_n_ff;
  logic              burst_mode_ff;
  logic [3:0]        burst_limit;

  assign apb_in.psel    = psel;
  assign apb_in.penable = penable;
  assign apb_in.pwrite  = pwrite;
  assign apb_in.paddr   = paddr;
  assign apb_in.pwdata  = pwdata;
  assign prdata         = apb_out.prdata;
  assign pready         = apb_out.pready;
  assign pslverr        = apb_out.pslverr;

  bcc_regs u_regs (
    .pclk       (pclk),
    .presetn    (presetn),
    .hw_standby (hw_standby),
    .apb_in     (apb_in),
    .apb_out    (apb_out),
    .cfg        (cfg)
  );

  // software must keep clear of reserved space; such requests are refused with a fault
  bcc_space_decode u_decode (
    .addr                   (int_req.addr),
    .ext_addr_window_enable (cfg.ext_addr_window_enable),
    .expanded_mode          (expanded_mode),
    .space                  (space)
  );

  // burst limit follows the settings latched for the running burst
  assign burst_limit = cyc_cfg_ff.burst_word_max ? BURST_WORDS_LONG : BURST_WORDS_SHORT;

  // a new request starts an external cycle only from idle and when no ack is pending
  assign ext_start   = state_ff == ST_IDLE && int_req.valid && !ack_ff && space == SPACE_EXT;
  assign release_req = cfg.bus_release_enable && !ext_master_request_n;

  always_comb begin
    need_gap = 1'b0;
    if (last_valid_ff && last_read_ff) begin
      if (!int_req.write && cfg.idle_cross_area_read
          && area_of(int_req.addr) != last_area_ff) begin
        need_gap = 1'b1;
      end
      if (int_req.write && cfg.idle_read_write) begin
        need_gap = 1'b1;
      end
    end
  end

  // a follow-on read of the next word in the open area-0 burst takes the short cycle
  assign can_burst = burst_open_ff && cfg.area0_burst_enable && !int_req.write
                     && area_of(int_req.addr) == 3'h0 && int_req.addr == burst_next_ff
                     && burst_cnt_ff < burst_limit;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (release_req && !ext_start) begin
          nxt_state = ST_RELEASED;
        end else if (ext_start) begin
          if (need_gap) nxt_state = ST_GAP;
          else if (can_burst) nxt_state = ST_BURST;
          else nxt_state = ST_T1;
        end
      end
      ST_GAP:      nxt_state = ST_T1;
      ST_T1:       nxt_state = ST_T2;
      ST_T2: begin
        if (wait_cnt_ff != 2'h0) nxt_state = ST_TW;
        else if (cyc_cfg_ff.wait_pin_enable && !wait_n) nxt_state = ST_TW;
        else nxt_state = ST_T3;
      end
      ST_TW: begin
        if (wait_cnt_ff > 2'h1) nxt_state = ST_TW;
        else if (cyc_cfg_ff.wait_pin_enable && !wait_n) nxt_state = ST_TW;
        else nxt_state = ST_T3;
      end
      ST_T3:       nxt_state = ST_IDLE;
      ST_BURST: begin
        if (cyc_cfg_ff.burst_cycle_len && !burst_step_ff) nxt_state = ST_BURST;
        else nxt_state = ST_IDLE;
      end
      ST_RELEASED: begin
        if (!release_req) nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_ff <= ST_IDLE;
    else          state_ff <= nxt_state;
  end

  // settings are frozen at cycle start so a mid-cycle write cannot disturb it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_cfg_ff <= '0;
      addr_ff    <= '0;
      write_ff   <= 1'b0;
      area_ff    <= 3'h0;
    end else if (ext_start) begin
      cyc_cfg_ff <= cfg;
      addr_ff    <= int_req.addr;
      write_ff   <= int_req.write;
      area_ff    <= area_of(int_req.addr);
    end
  end

  // programmed waits counted down first; the pin only extends after they run out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt_ff <= 2'h0;
    end else if (state_ff == ST_T1) begin
      wait_cnt_ff <= PROG_WAITS_RST;
    end else if (state_ff == ST_TW && wait_cnt_ff != 2'h0) begin
      wait_cnt_ff <= wait_cnt_ff - 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) burst_step_ff <= 1'b0;
    else          burst_step_ff <= state_ff == ST_BURST && !burst_step_ff;
  end

  // burst bookkeeping: a full area-0 read opens a burst, short reads extend it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      burst_open_ff <= 1'b0;
      burst_cnt_ff  <= 4'h0;
      burst_next_ff <= '0;
    end else if (state_ff == ST_T3 || (state_ff == ST_BURST && nxt_state == ST_IDLE)) begin
      burst_open_ff <= cyc_cfg_ff.area0_burst_enable && !write_ff && area_ff == 3'h0;
      burst_cnt_ff  <= state_ff == ST_T3 ? 4'h1 : burst_cnt_ff + 4'h1;
      burst_next_ff <= addr_ff + ADDR_W'(WORD_BYTES);
    end else if (ext_start && !can_burst) begin
      burst_open_ff <= 1'b0;
    end
  end

  // history of the previous external cycle for idle insertion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_valid_ff <= 1'b0;
      last_read_ff  <= 1'b0;
      last_area_ff  <= 3'h0;
    end else if (state_ff == ST_T3 || (state_ff == ST_BURST && nxt_state == ST_IDLE)) begin
      last_valid_ff <= 1'b1;
      last_read_ff  <= !write_ff;
      last_area_ff  <= area_ff;
    end else if (state_ff == ST_RELEASED) begin
      last_valid_ff <= 1'b0;
    end
  end

  // acknowledge to the internal master; non-external targets answer at once unless a bus release is requested or in progress
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_ff   <= 1'b0;
      fault_ff <= 1'b0;
    end else if (ack_ff) begin
      ack_ff   <= 1'b0;
      fault_ff <= 1'b0;
    end else if (state_ff == ST_IDLE && int_req.valid && space != SPACE_EXT
                 && !release_req) begin
      ack_ff   <= 1'b1;
      fault_ff <= space == SPACE_RSVD;
    end else begin
      ack_ff   <= state_ff == ST_T3 || (state_ff == ST_BURST && nxt_state == ST_IDLE);
      fault_ff <= 1'b0;
    end
  end

  // strobes and selects: selects and read strobe active through t1 to t3 and burst states, write strobe only from t2 to t3
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_n_ff <= '1;
      rd_n_ff  <= 1'b1;
      wr_n_ff  <= 1'b1;
    end else begin
      sel_n_ff <= '1;
      rd_n_ff  <= 1'b1;
      wr_n_ff  <= 1'b1;
      if (nxt_state inside {ST_T1, ST_T2, ST_TW, ST_T3, ST_BURST}) begin
        sel_n_ff[nxt_state == ST_T1 || (state_ff == ST_IDLE && nxt_state == ST_BURST)
                 ? area_of(int_req.addr) : area_ff] <= 1'b0;
        if (nxt_state != ST_T1 && nxt_state != ST_BURST && write_ff) begin
          wr_n_ff <= 1'b0;
        end else if (!(nxt_state == ST_T1 ? int_req.write : write_ff)) begin
          rd_n_ff <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ext_addr <= '0;
    else if (ext_start) ext_addr <= int_req.addr;
  end

  // bus release handshake pins; as general i/o they are left undriven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_ack_n_ff <= 1'b1;
      ack_oe_ff    <= 1'b0;
      drop_n_ff    <= 1'b1;
      drop_oe_ff   <= 1'b0;
    end else begin
      ack_oe_ff    <= cfg.bus_release_enable;
      bus_ack_n_ff <= nxt_state != ST_RELEASED;
      drop_oe_ff   <= cfg.bus_release_enable && cfg.req_drop_out_enable;
      drop_n_ff    <= !(cfg.bus_release_enable && cfg.req_drop_out_enable
                        && state_ff == ST_RELEASED
                        && int_req.valid && space == SPACE_EXT);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) burst_mode_ff <= 1'b0;
    else          burst_mode_ff <= cfg.area0_burst_enable;
  end

  assign int_ack          = ack_ff;
  assign int_fault        = fault_ff;
  assign bus_ack_n        = bus_ack_n_ff;
  assign bus_ack_oe       = ack_oe_ff;
  assign request_drop_n   = drop_n_ff;
  assign request_drop_oe  = drop_oe_ff;
  assign area_select_n    = sel_n_ff;
  assign ext_rd_n         = rd_n_ff;
  assign ext_wr_n         = wr_n_ff;
  assign area0_burst_mode = burst_mode_ff;

endmodule : bus_control_config_regs

// ==== tb/bcc_properties.sv ====
// port-level checks for the bus control block
`timescale 1ns/1ns
module bcc_properties (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       hw_standby,
  input wire bcc_pkg::ext_req_t          int_req,
  input wire logic                       int_ack,
  input wire logic                       int_fault,
  input wire logic                       ext_master_request_n,
  input wire logic                       bus_ack_n,
  input wire logic                       bus_ack_oe,
  input wire logic                       request_drop_n,
  input wire logic                       request_drop_oe,
  input wire logic [bcc_pkg::AREAS-1:0]  area_select_n,
  input wire logic [bcc_pkg::ADDR_W-1:0] ext_addr,
  input wire logic                       ext_rd_n,
  input wire logic                       ext_wr_n,
  input wire logic                       area0_burst_mode
);
  import bcc_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // outputs are copies of register bits, so they lag the reload by one edge
  chk_standby_upper: assert property (hw_standby |=> ##1 !area0_burst_mode)
    else $error("burst mode kept through standby");
  chk_standby_lower: assert property (hw_standby |=> ##1 (!bus_ack_oe && !request_drop_oe))
    else $error("release enables kept through standby");
  chk_sel_onehot: assert property ($onehot0(~area_select_n))
    else $error("more than one area select low");
  chk_sel_area: assert property ((!ext_rd_n || !ext_wr_n)
      |-> area_select_n == ~(8'h01 << ext_addr[23:21]))
    else $error("area select does not match address");
  chk_release_gate: assert property (!bus_ack_oe |-> bus_ack_n)
    else $error("bus released while release disabled");
  chk_release_cause: assert property ($fell(bus_ack_n)
      |-> !$past(ext_master_request_n) && bus_ack_oe)
    else $error("bus released without request");
  chk_release_quiet: assert property (!bus_ack_n
      |-> (&area_select_n && ext_rd_n && ext_wr_n))
    else $error("strobes active while released");
  chk_release_end: assert property ((!bus_ack_n && ext_master_request_n)
      |-> ##[1:2] bus_ack_n)
    else $error("bus not taken back");
  chk_drop_cause: assert property (!request_drop_n
      |-> request_drop_oe && (!bus_ack_n || !$past(bus_ack_n)))
    else $error("drop request outside release");
  chk_drop_enable: assert property (request_drop_oe |-> bus_ack_oe)
    else $error("drop output enabled without release");
  chk_fault_ack: assert property (int_fault |-> int_ack)
    else $error("fault without acknowledge");
endmodule : bcc_properties

bind bus_control_config_regs bcc_properties u_props (.pclk, .presetn, .hw_standby, .int_req,
  .int_ack, .int_fault, .ext_master_request_n, .bus_ack_n, .bus_ack_oe, .request_drop_n,
  .request_drop_oe, .area_select_n, .ext_addr, .ext_rd_n, .ext_wr_n, .area0_burst_mode);

// ==== tb/bcc_ext_partner.sv ====
// far side: an external master and a memory that stretches cycles by wait_n
`timescale 1ns/1ns
module bcc_ext_partner (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ext_rd_n,
  input  wire logic       ext_wr_n,
  input  wire logic       want_bus,
  input  wire logic [3:0] extra_waits,
  output logic            wait_n,
  output logic            ext_master_request_n
);
  logic [3:0] age_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) age_ff <= 4'h0;
    else if (!ext_rd_n || !ext_wr_n) age_ff <= age_ff + 4'h1;
    else age_ff <= 4'h0;
  end
  // low from the last programmed wait on, so each low sample adds one state
  assign wait_n = !(age_ff >= 4'h4 && age_ff < 4'h4 + extra_waits);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ext_master_request_n <= 1'b1;
    else ext_master_request_n <= !want_bus;
  end
endmodule : bcc_ext_partner

// ==== tb/tb.sv ====
// self-checking bench for the bus control configuration block
`timescale 1ns/1ns
module tb;
  import bcc_pkg::*;
  typedef struct packed {
    logic [7:0] up, lo; logic [3:0] xw; logic xm; logic [23:0] a; logic w, f; logic [7:0] n;
  } row_t;
  logic pclk, presetn, hw_standby, expanded_mode, psel, penable, pwrite, pready, pslverr;
  logic int_ack, int_fault, wait_n, ext_master_request_n, bus_ack_n, bus_ack_oe, want_bus;
  logic request_drop_n, request_drop_oe, ext_rd_n, ext_wr_n, area0_burst_mode;
  logic [PADDR_W-1:0] paddr;
  logic [31:0]        pwdata, prdata;
  logic [AREAS-1:0]   area_select_n;
  logic [ADDR_W-1:0]  ext_addr;
  logic [3:0]         extra_waits;
  logic [7:0]         seen_sel;
  logic [1:0]         seen_rw;
  ext_req_t           int_req;
  int                 n_errors, total_checks, cyc;
  row_t rows [16] = '{
    '{8'h00,8'h3c,4'h0,1'b1,24'h600000,1'b0,1'b0,8'h08},
    '{8'h00,8'h3c,4'h0,1'b1,24'ha00000,1'b0,1'b0,8'h08},
    '{8'h00,8'h3c,4'h0,1'b1,24'ha00000,1'b1,1'b0,8'h08},
    '{8'h80,8'h3c,4'h0,1'b1,24'h600000,1'b0,1'b0,8'h08},
    '{8'h80,8'h3c,4'h0,1'b1,24'ha00000,1'b0,1'b0,8'h09},
    '{8'h80,8'h3c,4'h0,1'b1,24'ha00000,1'b0,1'b0,8'h08},
    '{8'h80,8'h3c,4'h0,1'b1,24'h600000,1'b1,1'b0,8'h08},
    '{8'h40,8'h3c,4'h0,1'b1,24'h600000,1'b0,1'b0,8'h08},
    '{8'h40,8'h3c,4'h0,1'b1,24'h600000,1'b1,1'b0,8'h09},
    '{8'h00,8'h3d,4'h2,1'b1,24'h600000,1'b0,1'b0,8'h0a},
    '{8'h00,8'h3c,4'h2,1'b1,24'h600000,1'b0,1'b0,8'h08},
    '{8'h00,8'h3c,4'h0,1'b0,24'h020000,1'b0,1'b1,8'h02},
    '{8'h00,8'h1c,4'h0,1'b0,24'h010000,1'b0,1'b0,8'h02},
    '{8'h00,8'h1c,4'h0,1'b0,24'h020000,1'b0,1'b1,8'h02},
    '{8'h00,8'h1c,4'h0,1'b1,24'h020000,1'b0,1'b1,8'h02},
    '{8'h00,8'h3c,4'h0,1'b1,24'h020000,1'b0,1'b0,8'h08}};

  bus_control_config_regs uut (.pclk, .presetn, .hw_standby, .expanded_mode, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .int_req, .int_ack, .int_fault, .wait_n,
    .ext_master_request_n, .bus_ack_n, .bus_ack_oe, .request_drop_n, .request_drop_oe,
    .area_select_n, .ext_addr, .ext_rd_n, .ext_wr_n, .area0_burst_mode);
  bcc_ext_partner u_far (.pclk, .presetn, .ext_rd_n, .ext_wr_n, .want_bus, .extra_waits, .wait_n,
    .ext_master_request_n);

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic results();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      results();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // request held until pready is sampled high, then released
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // counts edges from presenting the request to the one that samples int_ack
  task automatic ext_op(input logic [ADDR_W-1:0] a, input logic w, output int n, output logic f);
    @(posedge pclk);
    int_req <= '{valid: 1'b1, write: w, addr: a};
    n = 0;
    seen_sel = 8'h00;
    seen_rw = 2'h0;
    do begin
      @(posedge pclk);
      n++;
      seen_sel |= ~area_select_n;
      seen_rw |= {!ext_wr_n, !ext_rd_n};
    end while (int_ack !== 1'b1);
    f = int_fault;
    int_req <= '0;
  endtask : ext_op

  task automatic t_regs();
    logic [31:0] q;
    logic e;
    apb(1'b0, OFS_BUS_CTRL_UPPER, 32'h0, q, e);
    chk("upper reset", 32'hd0, q);
    apb(1'b0, OFS_BUS_CTRL_LOWER, 32'h0, q, e);
    chk("lower reset", 32'h3c, q);
    apb(1'b1, OFS_BUS_CTRL_UPPER, 32'hffff_fff8, q, e);
    apb(1'b1, OFS_BUS_CTRL_LOWER, 32'h0000_00fd, q, e);
    apb(1'b1, 8'h08, 32'h0000_0055, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    apb(1'b0, 8'h08, 32'h0, q, e);
    chk("unmapped data", 32'h0, q);
    apb(1'b0, OFS_BUS_CTRL_UPPER, 32'h0, q, e);
    chk("upper stored", 32'hf8, q);
    apb(1'b0, OFS_BUS_CTRL_LOWER, 32'h0, q, e);
    chk("lower stored", 32'hfd, q);
    chk("area0 mode", 32'h1, {31'h0, area0_burst_mode});
  endtask : t_regs

  task automatic t_standby();
    logic [31:0] q;
    logic e;
    @(posedge pclk);
    hw_standby <= 1'b1;
    @(posedge pclk);
    hw_standby <= 1'b0;
    apb(1'b0, OFS_BUS_CTRL_UPPER, 32'h0, q, e);
    chk("upper standby", 32'hd0, q);
    apb(1'b0, OFS_BUS_CTRL_LOWER, 32'h0, q, e);
    chk("lower standby", 32'h3c, q);
  endtask : t_standby

  task automatic t_ext_table();
    logic [31:0] q, x;
    logic e, f;
    int n;
    foreach (rows[i]) begin
      apb(1'b1, OFS_BUS_CTRL_UPPER, {24'h0, rows[i].up}, q, e);
      apb(1'b1, OFS_BUS_CTRL_LOWER, {24'h0, rows[i].lo}, q, e);
      @(posedge pclk);
      expanded_mode <= rows[i].xm;
      extra_waits <= rows[i].xw;
      ext_op(rows[i].a, rows[i].w, n, f);
      chk("cycle length", {24'h0, rows[i].n}, n);
      chk("fault", {31'h0, rows[i].f}, {31'h0, f});
      // only rows longer than two edges reach external space
      x = (rows[i].n > 8'h02) ? (32'h1 << rows[i].a[23:21]) : 32'h0;
      chk("selects", x, {24'h0, seen_sel});
      x = (rows[i].n > 8'h02) ? (rows[i].w ? 32'h2 : 32'h1) : 32'h0;
      chk("strobes", x, {30'h0, seen_rw});
    end
  endtask : t_ext_table

  task automatic t_burst();
    logic [31:0] q;
    logic e, f;
    int n, last;
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, OFS_BUS_CTRL_UPPER, s ? 32'h38 : 32'h20, q, e);
      last = s ? 8 : 4;
      for (int i = 0; i <= last; i++) begin
        ext_op(24'h000100 + 24'(s * 256 + 2 * i), 1'b0, n, f);
        chk("burst length", (i == 0 || i == last) ? 8 : 3 + s, n);
      end
      chk("area0 burst", 32'h1, {31'h0, area0_burst_mode});
    end
  endtask : t_burst

  task automatic t_release();
    logic [31:0] q;
    logic e, f;
    int n;
    apb(1'b1, OFS_BUS_CTRL_UPPER, 32'h0, q, e);
    apb(1'b1, OFS_BUS_CTRL_LOWER, 32'h3c, q, e);
    @(posedge pclk);
    want_bus <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("ack while disabled", 32'h1, {31'h0, bus_ack_n});
    apb(1'b1, OFS_BUS_CTRL_LOWER, 32'hfc, q, e);
    repeat (3) @(posedge pclk);
    chk("bus ack", 32'h0, {31'h0, bus_ack_n});
    chk("enables", 32'h3, {30'h0, bus_ack_oe, request_drop_oe});
    fork
      ext_op(24'h600000, 1'b0, n, f);
      begin
        repeat (4) @(posedge pclk);
        chk("drop request", 32'h0, {31'h0, request_drop_n});
        want_bus <= 1'b0;
      end
    join
    chk("bus back", 32'h1, {31'h0, bus_ack_n});
  endtask : t_release

  initial begin
    {presetn, hw_standby, psel, penable, pwrite, want_bus} = 6'h00;
    expanded_mode = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    int_req = '0;
    extra_waits = 4'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_standby();
    t_ext_table();
    t_burst();
    t_release();
    results();
  end
endmodule : tb
